// >>> design/alrm_persist.sv
// Consecutive-sample counter for one threshold bound.
// Assumes sample is a one-cycle pulse per new result.
`timescale 1ns/1ps
`default_nettype none
module alrm_persist (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sample,
  input wire logic beyond,
  input wire logic [3:0] need,
  output logic hit
);

  logic [3:0] count_r;
  logic [3:0] count_nxt;

  // ****************************************
  // Run counter
  // ****************************************
  always_comb begin
    count_nxt = 4'(count_r + 4'h1);
    // At least need, so a shortened persistence acts at once
    hit = sample && beyond && (count_nxt >= need);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 4'h0;
    end else if (clear) begin
      count_r <= 4'h0;
    end else if (sample) begin
      // Restart after a hit so the next flag needs a fresh run
      if (!beyond || hit) begin
        count_r <= 4'h0;
      end else begin
        count_r <= count_nxt;
      end
    end
  end

  a_hit_after_run: assert property (
    @(posedge clk) disable iff (!rst_n)
    hit |-> (count_r >= 4'(need - 4'h1)) && beyond && sample)
    else $error("threshold hit before the run was long enough");

endmodule : alrm_persist
`default_nettype wire

// >>> design/alrm_pkg.sv
// Constants shared by the ambient light register map block.
// Assumes one 10 MHz clock and an I2C bus sampled synchronously.
package alrm_pkg;

  // ****************************************
  // Bus address and command codes
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h10;
  localparam logic [7:0] CMD_CONFIG = 8'h00;
  localparam logic [7:0] CMD_UPPER = 8'h01;
  localparam logic [7:0] CMD_LOWER = 8'h02;
  localparam logic [7:0] CMD_PSAVE = 8'h03;
  localparam logic [7:0] CMD_AMBIENT = 8'h04;
  localparam logic [7:0] CMD_BROAD = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h06;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CFG_RESET = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_GAIN_MSB = 12;
  localparam int CFG_GAIN_LSB = 11;
  localparam int CFG_IT_MSB = 9;
  localparam int CFG_IT_LSB = 6;
  localparam int CFG_PERS_MSB = 5;
  localparam int CFG_PERS_LSB = 4;
  localparam int CFG_EVT_EN = 1;
  localparam int CFG_SD = 0;
  localparam int PS_LVL_MSB = 2;
  localparam int PS_LVL_LSB = 1;
  localparam int PS_EN = 0;
  localparam int STS_BELOW = 15;
  localparam int STS_ABOVE = 14;

  // ****************************************
  // Serial framing and persistence base
  // ****************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PERS_BASE = 4'h1;
  localparam logic [1:0] BI_ADDR = 2'h0;
  localparam logic [1:0] BI_CMD = 2'h1;
  localparam logic [1:0] BI_LO = 2'h2;
  localparam logic [1:0] BI_HI = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_RACK
  } alrm_state_e;

endpackage : alrm_pkg

// >>> design/alrm_top.sv
// Register map and I2C word slave of an ambient light sensor.
// Assumes scl and sda are already synchronous to clk; results arrive
// from the measurement path as a word pair with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module alrm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic result_valid,
  input wire logic [15:0] ambient_in,
  input wire logic [15:0] broadband_in,
  output logic [1:0] gain_select,
  output logic [3:0] integration_time_select,
  output logic sensor_shutdown,
  output logic [1:0] power_save_level,
  output logic power_save_enable
);

  // ****************************************
  // Bus line sampling
  // ****************************************
  logic scl_q_r, sda_q_r;
  logic start_c, stop_c, rise_c, fall_c;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  assign start_c = scl_in && scl_q_r && sda_q_r && !sda_in;
  assign stop_c = scl_in && scl_q_r && !sda_q_r && sda_in;
  assign rise_c = scl_in && !scl_q_r;
  assign fall_c = !scl_in && scl_q_r;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] config_r, upper_r, lower_r, ambient_r, broad_r;
  logic [2:0] psave_r;
  logic below_r, above_r;

  // ****************************************
  // Serial engine
  // ****************************************
  alrm_pkg::alrm_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, cmd_r, lo_r, hi_pend_r;
  logic [1:0] byte_idx_r;
  logic rd_mode_r, sent_hi_r, host_ack_r, sda_oe_r;
  logic byte_done_c, commit_c, load_c;
  logic [15:0] rd_word_c, wr_word_c;
  assign byte_done_c = (state_r == alrm_pkg::ST_RECV) && fall_c &&
                       (bit_cnt_r == alrm_pkg::BITS_PER_BYTE);
  assign commit_c = byte_done_c && (byte_idx_r == alrm_pkg::BI_HI);
  assign load_c = (state_r == alrm_pkg::ST_ACK) && fall_c && rd_mode_r &&
                  (byte_idx_r == alrm_pkg::BI_CMD);
  assign wr_word_c = {shift_r, lo_r};
  always_comb begin
    rd_word_c = alrm_pkg::WORD_ZERO;
    case (cmd_r)
      alrm_pkg::CMD_CONFIG: rd_word_c = config_r;
      alrm_pkg::CMD_UPPER: rd_word_c = upper_r;
      alrm_pkg::CMD_LOWER: rd_word_c = lower_r;
      alrm_pkg::CMD_PSAVE: rd_word_c = {13'h0000, psave_r};
      alrm_pkg::CMD_AMBIENT: rd_word_c = ambient_r;
      alrm_pkg::CMD_BROAD: rd_word_c = broad_r;
      alrm_pkg::CMD_STATUS: begin
        rd_word_c[alrm_pkg::STS_BELOW] = below_r;
        rd_word_c[alrm_pkg::STS_ABOVE] = above_r;
      end
      default: rd_word_c = alrm_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= alrm_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      byte_idx_r <= alrm_pkg::BI_ADDR;
      rd_mode_r <= 1'b0;
      cmd_r <= 8'h00;
      lo_r <= 8'h00;
      hi_pend_r <= 8'h00;
      sent_hi_r <= 1'b0;
      host_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      state_r <= alrm_pkg::ST_RECV;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= alrm_pkg::BI_ADDR;
      sda_oe_r <= 1'b0;
    end else if (stop_c) begin
      state_r <= alrm_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        alrm_pkg::ST_RECV: begin
          if (rise_c) begin
            shift_r <= {shift_r[6:0], sda_in};
            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
          end else if (byte_done_c) begin
            bit_cnt_r <= 4'h0;
            byte_idx_r <= 2'(byte_idx_r + 2'h1);
            state_r <= alrm_pkg::ST_ACK;
            sda_oe_r <= 1'b1;
            case (byte_idx_r)
              alrm_pkg::BI_ADDR: begin
                // Foreign address: stay off the bus until next start
                if (shift_r[7:1] != alrm_pkg::DEV_ADDR) begin
                  state_r <= alrm_pkg::ST_IDLE;
                  sda_oe_r <= 1'b0;
                end
                rd_mode_r <= shift_r[0];
              end
              alrm_pkg::BI_CMD: cmd_r <= shift_r;
              alrm_pkg::BI_LO: lo_r <= shift_r;
              default: lo_r <= lo_r;
            endcase
          end
        end
        alrm_pkg::ST_ACK: begin
          if (fall_c) begin
            sda_oe_r <= 1'b0;
            if (load_c) begin
              shift_r <= rd_word_c[7:0];
              hi_pend_r <= rd_word_c[15:8];
              sent_hi_r <= 1'b0;
              sda_oe_r <= !rd_word_c[7];
              state_r <= alrm_pkg::ST_SEND;
            end else if (byte_idx_r == alrm_pkg::BI_ADDR) begin
              state_r <= alrm_pkg::ST_IDLE;
            end else begin
              state_r <= alrm_pkg::ST_RECV;
            end
          end
        end
        alrm_pkg::ST_SEND: begin
          if (rise_c) begin
            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
          end else if (fall_c) begin
            if (bit_cnt_r == alrm_pkg::BITS_PER_BYTE) begin
              sda_oe_r <= 1'b0;
              state_r <= alrm_pkg::ST_RACK;
            end else begin
              sda_oe_r <= !shift_r[6];
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
        end
        alrm_pkg::ST_RACK: begin
          if (rise_c) begin
            host_ack_r <= !sda_in;
          end else if (fall_c) begin
            if (host_ack_r && !sent_hi_r) begin
              shift_r <= hi_pend_r;
              sent_hi_r <= 1'b1;
              bit_cnt_r <= 4'h0;
              sda_oe_r <= !hi_pend_r[7];
              state_r <= alrm_pkg::ST_SEND;
            end else begin
              state_r <= alrm_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= alrm_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain line: only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
  assign sda_oe = sda_oe_r;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_r <= alrm_pkg::CFG_RESET;
      upper_r <= alrm_pkg::WORD_ZERO;
      lower_r <= alrm_pkg::WORD_ZERO;
      psave_r <= 3'h0;
    end else if (commit_c) begin
      case (cmd_r)
        alrm_pkg::CMD_CONFIG: config_r <= wr_word_c;
        alrm_pkg::CMD_UPPER: upper_r <= wr_word_c;
        alrm_pkg::CMD_LOWER: lower_r <= wr_word_c;
        // Upper bits are expected zero and are not kept
        alrm_pkg::CMD_PSAVE: psave_r <= wr_word_c[2:0];
        default: psave_r <= psave_r;
      endcase
    end
  end

  // Reserved configuration bits are stored as written
  assign gain_select = config_r[alrm_pkg::CFG_GAIN_MSB:
                                alrm_pkg::CFG_GAIN_LSB];
  assign integration_time_select = config_r[alrm_pkg::CFG_IT_MSB:
                                            alrm_pkg::CFG_IT_LSB];
  assign sensor_shutdown = config_r[alrm_pkg::CFG_SD];
  assign power_save_level = psave_r[alrm_pkg::PS_LVL_MSB:
                                    alrm_pkg::PS_LVL_LSB];
  assign power_save_enable = psave_r[alrm_pkg::PS_EN];

  // ****************************************
  // Results and threshold events
  // ****************************************
  logic evt_en_c, sample_c, hit_below_c, hit_above_c, clr_sts_c;
  logic [3:0] need_c;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ambient_r <= alrm_pkg::WORD_ZERO;
      broad_r <= alrm_pkg::WORD_ZERO;
    end else if (result_valid && !sensor_shutdown) begin
      ambient_r <= ambient_in;
      broad_r <= broadband_in;
    end
  end
  assign evt_en_c = config_r[alrm_pkg::CFG_EVT_EN];
  assign sample_c = result_valid && !sensor_shutdown && evt_en_c;
  assign need_c = 4'(alrm_pkg::PERS_BASE <<
                  config_r[alrm_pkg::CFG_PERS_MSB:
                           alrm_pkg::CFG_PERS_LSB]);
  assign clr_sts_c = load_c && (cmd_r == alrm_pkg::CMD_STATUS);
  alrm_persist u_below (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!evt_en_c),
    .sample(sample_c),
    .beyond(ambient_in < lower_r),
    .need(need_c),
    .hit(hit_below_c)
  );
  alrm_persist u_above (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!evt_en_c),
    .sample(sample_c),
    .beyond(ambient_in > upper_r),
    .need(need_c),
    .hit(hit_above_c)
  );

  // Set beats the read-clear so no event is lost; polled only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      below_r <= 1'b0;
      above_r <= 1'b0;
    end else begin
      below_r <= hit_below_c || (below_r && !clr_sts_c);
      above_r <= hit_above_c || (above_r && !clr_sts_c);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cfg_write: assert property (
    commit_c && (cmd_r == alrm_pkg::CMD_CONFIG) |=>
    config_r == $past(wr_word_c))
    else $error("configuration word not taken");
  a_upper_write: assert property (
    commit_c && (cmd_r == alrm_pkg::CMD_UPPER) |=>
    upper_r[15:8] == $past(shift_r) && upper_r[7:0] == $past(lo_r))
    else $error("upper bound bytes misplaced");
  a_lower_write: assert property (
    commit_c && (cmd_r == alrm_pkg::CMD_LOWER) |=>
    lower_r == $past(wr_word_c))
    else $error("lower bound not taken");
  a_result_load: assert property (
    result_valid && !sensor_shutdown |=>
    ambient_r == $past(ambient_in) && broad_r == $past(broadband_in))
    else $error("result not loaded");
  a_result_hold: assert property (
    sensor_shutdown && !commit_c |=> $stable(ambient_r) && $stable(broad_r))
    else $error("result changed while shut down");
  a_event_enable: assert property (
    $rose(below_r) || $rose(above_r) |->
    $past(evt_en_c) && !$past(sensor_shutdown))
    else $error("event flagged while disabled");
  a_psave_write: assert property (
    commit_c && (cmd_r == alrm_pkg::CMD_PSAVE) |=>
    {power_save_level, power_save_enable} == $past(lo_r[2:0]))
    else $error("power save word not taken");
  a_addr_ack: assert property (
    byte_done_c && (byte_idx_r == alrm_pkg::BI_ADDR) &&
    (shift_r[7:1] != alrm_pkg::DEV_ADDR) |=> !sda_oe_r [*2])
    else $error("acknowledged a foreign address");
  a_flag_kept: assert property (
    below_r && !clr_sts_c |=> below_r)
    else $error("below flag lost without a read");
endmodule : alrm_top
`default_nettype wire

// >>> testbench/alrm_host.sv
// Host I2C controller model speaking the word protocol.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module alrm_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ****************************************
  // Bus phases
  // ****************************************
  // Four clocks a phase, above the one that the device needs
  task automatic tick();
    repeat (4) @(posedge clk);
    #1;
  endtask : tick
  task automatic start_c();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask : stop_c
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tick();
      sda_low = ~b[i];
      tick();
      scl = 1'b1;
      tick();
      scl = 1'b0;
    end
    tick();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    ack = ~sda_line;
    tick();
    scl = 1'b0;
  endtask : send_byte
  task automatic recv_byte(input logic ack_in, output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick();
      tick();
      scl = 1'b1;
      b[i] = sda_line;
      tick();
      scl = 1'b0;
    end
    tick();
    sda_low = ack_in;
    tick();
    scl = 1'b1;
    tick();
    scl = 1'b0;
  endtask : recv_byte
  // ****************************************
  // Word transfers, low byte first
  // ****************************************
  // Low address bit selects write (0) or read (1)
  task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] acks);
    start_c();
    send_byte({addr, 1'b0}, acks[3]);
    send_byte(cmd, acks[2]);
    send_byte(d[7:0], acks[1]);
    send_byte(d[15:8], acks[0]);
    stop_c();
  endtask : write_word
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    start_c();
    send_byte(8'h20, a);
    send_byte(cmd, a);
    start_c();
    send_byte(8'h21, a);
    recv_byte(1'b1, d[7:0]);
    recv_byte(1'b0, d[15:8]);
    stop_c();
  endtask : read_word
endmodule : alrm_host
`default_nettype wire

// >>> testbench/alrm_top_tb_top.sv
// Self-checking bench for the ambient light register map.
// Assumes the host model and the design share one open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module alrm_top_tb_top;
  logic clk, rst_n, scl, sda_low, sda_line, sda_out, sda_oe, result_valid;
  logic [15:0] ambient_in, broadband_in, d, cfg, up, lo;
  logic [1:0] gain_select, power_save_level;
  logic [3:0] integration_time_select, a;
  logic sensor_shutdown, power_save_enable;
  logic [31:0] r;
  logic [3:0] it_tab [6] = '{4'hc, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
  int errors = 0;
  int n_tests = 0;
  // Pull-up wins unless someone pulls low
  assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  alrm_top alrm_top_i (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .result_valid(result_valid), .ambient_in(ambient_in),
    .broadband_in(broadband_in), .gain_select(gain_select),
    .integration_time_select(integration_time_select),
    .sensor_shutdown(sensor_shutdown), .power_save_level(power_save_level),
    .power_save_enable(power_save_enable));
  alrm_host alrm_host_i (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));
  // ****************************************
  // Helpers
  // ****************************************
  // Reserved bits always zero
  function automatic logic [15:0] mk_cfg(input logic [1:0] g,
      input logic [3:0] it, input logic [1:0] p, input logic en,
      input logic sd);
    return {3'h0, g, 1'b0, it, p, 2'h0, en, sd};
  endfunction : mk_cfg
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
    alrm_host_i.write_word(7'h10, cmd, v, a);
    check("ack", 16'(a), 16'h000f);
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp,
                    input string what);
    alrm_host_i.read_word(cmd, d);
    check(what, d, exp);
  endtask : rd
  task automatic pulse(input logic [15:0] amb);
    r = $urandom;
    ambient_in = amb;
    broadband_in = r[15:0];
    result_valid = 1'b1;
    @(posedge clk);
    #1;
    result_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse
  // ****************************************
  // Clock, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    result_valid = 1'b0;
    ambient_in = 16'h0000;
    broadband_in = 16'h0000;
    r = $urandom(75);
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("shutdown", 16'(sensor_shutdown), 16'h0001);
    check("psave", 16'({power_save_level, power_save_enable}),
          16'h0000);
    rd(alrm_pkg::CMD_CONFIG, alrm_pkg::CFG_RESET, "cfg reset");
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      cfg = mk_cfg(r[1:0] ^ 2'(i), it_tab[i], r[3:2], 1'b0, r[4]);
      wr(alrm_pkg::CMD_CONFIG, cfg);
      check("gain", 16'(gain_select), 16'(cfg[12:11]));
      check("itime", 16'(integration_time_select), 16'(cfg[9:6]));
      check("shutdown", 16'(sensor_shutdown), 16'(cfg[0]));
      rd(alrm_pkg::CMD_CONFIG, cfg, "cfg");
      r = $urandom;
      wr(alrm_pkg::CMD_PSAVE, {13'h0, r[2:0]});
      check("ps level", 16'(power_save_level), 16'(r[2:1]));
      check("ps enable", 16'(power_save_enable), 16'(r[0]));
    end
    alrm_host_i.write_word(7'h11, alrm_pkg::CMD_CONFIG, ~cfg, a);
    check("foreign ack", 16'(a), 16'h0000);
    rd(alrm_pkg::CMD_CONFIG, cfg, "cfg kept");
    wr(alrm_pkg::CMD_CONFIG, mk_cfg(2'h0, 4'h0, 2'h0, 1'b0, 1'b0));
    r = $urandom;
    up = 16'h8000 + 16'(r[13:0]);
    lo = 16'h0100 + 16'(r[29:16]);
    pulse(up);
    rd(alrm_pkg::CMD_AMBIENT, up, "ambient");
    rd(alrm_pkg::CMD_BROAD, broadband_in, "broadband");
    // Frozen results must survive shutdown
    wr(alrm_pkg::CMD_CONFIG, mk_cfg(2'h0, 4'h0, 2'h0, 1'b0, 1'b1));
    pulse(lo);
    rd(alrm_pkg::CMD_AMBIENT, up, "ambient held");
    wr(alrm_pkg::CMD_CONFIG, mk_cfg(2'h0, 4'h0, 2'h0, 1'b0, 1'b0));
    pulse(lo);
    rd(alrm_pkg::CMD_AMBIENT, lo, "ambient woke");
    wr(alrm_pkg::CMD_UPPER, up);
    wr(alrm_pkg::CMD_LOWER, lo);
    rd(alrm_pkg::CMD_UPPER, up, "upper");
    rd(alrm_pkg::CMD_LOWER, lo, "lower");
    repeat (8) pulse(up + 16'h0001);
    rd(alrm_pkg::CMD_STATUS, 16'h0000, "events off");
    for (int k = 0; k < 4; k++) begin
      wr(alrm_pkg::CMD_CONFIG, mk_cfg(2'h0, 4'h0, 2'(k), 1'b1, 1'b0));
      // Values on a bound are inside the window
      pulse(up);
      pulse(lo);
      repeat ((1 << k) - 1) pulse(up + 16'h0001);
      rd(alrm_pkg::CMD_STATUS, 16'h0000, "short run");
      pulse(up + 16'h0001);
      rd(alrm_pkg::CMD_STATUS, 16'h4000, "above");
      repeat (1 << k) pulse(lo - 16'h0001);
      rd(alrm_pkg::CMD_STATUS, 16'h8000, "below");
      rd(alrm_pkg::CMD_STATUS, 16'h0000, "cleared");
    end
    // Shorter persistence must not wait for the old run to wrap
    repeat (5) pulse(up + 16'h0001);
    wr(alrm_pkg::CMD_CONFIG, mk_cfg(2'h0, 4'h0, 2'h0, 1'b1, 1'b0));
    pulse(up + 16'h0001);
    rd(alrm_pkg::CMD_STATUS, 16'h4000, "shorter run");
    report_and_stop();
  end
endmodule : alrm_top_tb_top
`default_nettype wire
